// ==== hbe_master.sv ====
// Purpose: Host bus emulation master toward an 8-bit multiplexed bus.
// Assumes: Commands arrive from the command engine on CORE_CLK_I.
// Notes: Pins from outside pass two flip-flops before use.
import hbe_pkg::*;

// Behaviour
// R1: Both channels form one bus master.
// R2: Low address and data share bus.
// R3: Upper address bits driven on own lines.
// R4: Select low during each read and write.
// R5: Latch pulse while low address is driven.
// R6: Read strobe low; sample peripheral data.
// R7: Write strobe low for each write.
// R8: Write data stable around write strobe.
// R9: Ready low stretches the access.
// R10: Interface clock driven on output pin.
// R11: Spare line zero set, cleared, read.
// R12: Stall until wait line high or low.
// R13: Wait for interrupt, then read, return.
// R14: Wait line kept as input when waiting.
// R15: Latch ends, address released before strobe.
module hbe_master
   import hbe_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   // Mode and command port
   input wire logic EMU_ENABLE_I,
   input wire logic CMD_VALID_I,
   input wire cmd_t CMD_I,
   output logic CMD_READY_O,
   output logic RESULT_VALID_O,
   output logic [7:0] RESULT_O,
   // Shared address and data bus
   input wire logic [7:0] AD_I,
   output logic [7:0] AD_O,
   output logic AD_OE_O,
   // Dedicated bus control
   output logic [7:0] ADDR_HIGH_O,
   output logic SEL_N_O,
   output logic LATCH_O,
   output logic RD_N_O,
   output logic WR_N_O,
   input wire logic ACCESS_READY_I,
   output logic INTERFACE_CLOCK_O,
   // Spare lines
   input wire logic SPARE_ZERO_I,
   output logic SPARE_ZERO_O,
   output logic SPARE_ZERO_OE_O,
   input wire logic SPARE_WAIT_I,
   output logic SPARE_WAIT_O,
   output logic SPARE_WAIT_OE_O
);
   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      state_t st;
      cmd_t cmd;
      bus_pins_t pins;
      logic [3:0] cnt;
      logic [1:0] rdy_s;
      logic [7:0] ad_m;
      logic [7:0] ad_s;
      logic [1:0] z_s;
      logic [1:0] w_s;
      logic cmd_ready;
      logic res_valid;
      logic [7:0] result;
      logic z_out;
      logic z_oe;
      logic ifclk;
   } state_all_t;
   state_all_t s_q, s_d;
   logic ifclk_w;

   hbe_clock_out hbe_clock_out_inst (
      .clk_i(CORE_CLK_I),
      .rst_i(SYS_RST_I),
      .ifclk_o(ifclk_w)
   );

   function automatic logic is_read(input cmd_op_t op);
      return (op == CMD_READ) || (op == CMD_IRQ_READ);
   endfunction

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      s_d = s_q;
      s_d.res_valid = 1'b0;
      s_d.ifclk = ifclk_w;                          // see R10
      s_d.rdy_s = {s_q.rdy_s[0], ACCESS_READY_I};
      s_d.ad_m = AD_I;
      s_d.ad_s = s_q.ad_m;
      s_d.z_s = {s_q.z_s[0], SPARE_ZERO_I};
      s_d.w_s = {s_q.w_s[0], SPARE_WAIT_I};
      if (s_q.cnt != 4'h0) begin
         s_d.cnt = s_q.cnt - 4'h1;
      end
      case (s_q.st)
         ST_IDLE: begin
            s_d.cmd_ready = EMU_ENABLE_I;           // see R1
            if (EMU_ENABLE_I && CMD_VALID_I && s_q.cmd_ready) begin
               s_d.cmd = CMD_I;
               s_d.cmd_ready = 1'b0;
               case (CMD_I.op)
                  CMD_SET_SPARE: begin
                     s_d.z_out = CMD_I.data[0];     // see R11
                     s_d.z_oe = CMD_I.data[1];
                     s_d.st = ST_DONE;
                  end
                  CMD_READ_SPARE: begin
                     s_d.result = {6'h00, s_q.w_s[1], s_q.z_s[1]}; // see R11
                     s_d.res_valid = 1'b1;
                     s_d.st = ST_DONE;
                  end
                  CMD_WAIT_HIGH, CMD_WAIT_LOW, CMD_IRQ_READ: begin
                     s_d.st = ST_WAIT;              // see R12
                  end
                  default: begin
                     s_d.st = ST_ADDR;
                  end
               endcase
            end
         end
         ST_WAIT: begin
            if ((s_q.cmd.op == CMD_WAIT_LOW) ? !s_q.w_s[1]
                                             : s_q.w_s[1]) begin
               s_d.st = (s_q.cmd.op == CMD_IRQ_READ) ? ST_ADDR
                                                     : ST_DONE; // see R13
            end
         end
         ST_ADDR: begin
            s_d.pins.addr_high = s_q.cmd.addr[15:8]; // see R3
            s_d.pins.ad_out = s_q.cmd.addr[7:0];     // see R2
            s_d.pins.ad_oe = 1'b1;
            s_d.pins.sel_n = 1'b0;                   // see R4
            s_d.pins.latch = 1'b1;                   // see R5
            s_d.cnt = PHASE_CYCLES - 4'h1;
            s_d.st = ST_LATCH;
         end
         ST_LATCH: begin
            if (s_q.cnt == 4'h0) begin
               s_d.pins.latch = 1'b0;                // see R15
               s_d.cnt = PHASE_CYCLES - 4'h1;
               s_d.st = ST_TURN;
            end
         end
         ST_TURN: begin
            if (is_read(s_q.cmd.op)) begin
               s_d.pins.ad_oe = 1'b0;                // see R15
            end else begin
               s_d.pins.ad_out = s_q.cmd.data;       // see R8
            end
            if (s_q.cnt == 4'h0) begin
               s_d.pins.rd_n = !is_read(s_q.cmd.op); // see R6
               s_d.pins.wr_n = is_read(s_q.cmd.op);  // see R7
               s_d.cnt = PHASE_CYCLES - 4'h1;
               s_d.st = ST_STROBE;
            end
         end
         ST_STROBE: begin
            if (s_q.cnt == 4'h0 && s_q.rdy_s[1]) begin // see R9
               s_d.pins.rd_n = 1'b1;
               s_d.pins.wr_n = 1'b1;
               s_d.cnt = PHASE_CYCLES - 4'h1;
               s_d.st = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (s_q.cnt == 4'h0) begin
               // The last byte sampled under the strobe leaves the sync here.
               if (is_read(s_q.cmd.op)) begin
                  s_d.result = s_q.ad_s;             // see R6
                  s_d.res_valid = 1'b1;              // see R13
               end
               s_d.pins.ad_oe = 1'b0;                // see R8
               s_d.pins.sel_n = 1'b1;
               s_d.st = ST_DONE;
            end
         end
         ST_DONE: begin
            s_d.st = ST_IDLE;
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         s_q <= '0;
         s_q.st <= ST_IDLE;
         s_q.pins <= PINS_RESET;
         s_q.rdy_s <= 2'b11;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign CMD_READY_O = s_q.cmd_ready;
   assign RESULT_VALID_O = s_q.res_valid;
   assign RESULT_O = s_q.result;
   assign AD_O = s_q.pins.ad_out;
   assign AD_OE_O = s_q.pins.ad_oe;
   assign ADDR_HIGH_O = s_q.pins.addr_high;
   assign SEL_N_O = s_q.pins.sel_n;
   assign LATCH_O = s_q.pins.latch;
   assign RD_N_O = s_q.pins.rd_n;
   assign WR_N_O = s_q.pins.wr_n;
   assign INTERFACE_CLOCK_O = s_q.ifclk;
   assign SPARE_ZERO_O = s_q.z_out;
   assign SPARE_ZERO_OE_O = s_q.z_oe;
   assign SPARE_WAIT_O = 1'b0;
   assign SPARE_WAIT_OE_O = 1'b0;                    // see R14
endmodule

// ==== hbe_pkg.sv ====
// Purpose: Shared types and constants for the host bus emulation master.
// Assumes: One core clock at 100 MHz; no software registers.
// Notes: Command codes are local to this block.
package hbe_pkg;
   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_PERIOD_NS = 10;
   localparam int PHASE_TIME_NS = 20;
   localparam logic [3:0] PHASE_CYCLES =
      4'((PHASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0] IFCLK_HALF_CYCLES = 4'h3;

   // ==========================================================
   // Commands
   // ==========================================================
   typedef enum logic [2:0] {
      CMD_READ = 3'b000,
      CMD_WRITE = 3'b001,
      CMD_SET_SPARE = 3'b010,
      CMD_READ_SPARE = 3'b011,
      CMD_WAIT_HIGH = 3'b100,
      CMD_WAIT_LOW = 3'b101,
      CMD_IRQ_READ = 3'b110
   } cmd_op_t;

   typedef struct packed {
      cmd_op_t op;
      logic [15:0] addr;
      logic [7:0] data;
   } cmd_t;

   typedef struct packed {
      logic [7:0] ad_out;
      logic ad_oe;
      logic [7:0] addr_high;
      logic sel_n;
      logic latch;
      logic rd_n;
      logic wr_n;
   } bus_pins_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_ADDR = 4'b0001,
      ST_LATCH = 4'b0010,
      ST_TURN = 4'b0011,
      ST_STROBE = 4'b0100,
      ST_HOLD = 4'b0101,
      ST_WAIT = 4'b0110,
      ST_DONE = 4'b0111
   } state_t;

   localparam bus_pins_t PINS_RESET = '{8'h00, 1'b0, 8'h00, 1'b1,
                                       1'b0, 1'b1, 1'b1};
endpackage

// ==== hbe_clock_out.sv ====
// Purpose: Divider that makes the interface clock.
// Assumes: Synchronous active high reset.
// Notes: Output comes from a flip-flop.
module hbe_clock_out
   import hbe_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Divided clock
   output logic ifclk_o
);
   typedef struct packed {
      logic [3:0] cnt;
      logic level;
   } div_t;
   div_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      if (s_q.cnt == IFCLK_HALF_CYCLES - 4'h1) begin
         s_d.cnt = 4'h0;
         s_d.level = ~s_q.level;
      end else begin
         s_d.cnt = s_q.cnt + 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign ifclk_o = s_q.level;
endmodule

// ==== hbe_monitor.sv ====
// Purpose: Port checker for the host bus emulation master.
// Assumes: One clock domain; synchronous high reset.
// Notes: Bound to hbe_master at the foot of this file.
module hbe_monitor (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   // Watched ports
   input wire logic ACCESS_READY_I,
   input wire logic AD_OE_O,
   input wire logic SEL_N_O,
   input wire logic LATCH_O,
   input wire logic RD_N_O,
   input wire logic WR_N_O,
   input wire logic INTERFACE_CLOCK_O,
   input wire logic RESULT_VALID_O,
   input wire logic SPARE_WAIT_OE_O,
   input wire logic [7:0] AD_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   rd_sel_a:
      assert property (!RD_N_O |-> !SEL_N_O) else $error("rd no sel");
   wr_sel_a:
      assert property (!WR_N_O |-> !SEL_N_O) else $error("wr no sel");
   latch_addr_a:
      assert property (LATCH_O |-> AD_OE_O && !SEL_N_O)
      else $error("latch no addr");
   latch_pulse_a:
      assert property ($rose(LATCH_O) |=> LATCH_O ##1 !LATCH_O)
      else $error("latch width");
   wr_setup_a:
      assert property ($fell(WR_N_O) |-> AD_OE_O && $stable(AD_O))
      else $error("wr setup");
   wr_hold_a:
      assert property ($rose(WR_N_O) |-> AD_OE_O) else $error("wr hold");
   rd_release_a:
      assert property (!RD_N_O |-> !AD_OE_O) else $error("rd bus");
   strobe_order_a:
      assert property ($fell(RD_N_O) || $fell(WR_N_O) |->
         !LATCH_O && !$past(LATCH_O)) else $error("strobe order");
   ready_stretch_a:
      assert property (!ACCESS_READY_I [*4] ##0 !RD_N_O |=> !RD_N_O)
      else $error("no stretch");
   ifclk_high_a:
      assert property ($rose(INTERFACE_CLOCK_O) |=>
         INTERFACE_CLOCK_O [*2] ##1 !INTERFACE_CLOCK_O)
      else $error("ifclk");
   wait_input_a:
      assert property (!SPARE_WAIT_OE_O) else $error("wait driven");
   result_pulse_a:
      assert property (RESULT_VALID_O |=> !RESULT_VALID_O)
      else $error("result pulse");
   cover property ($fell(RD_N_O));
   cover property ($fell(WR_N_O));
   cover property (!ACCESS_READY_I && !RD_N_O);
endmodule

bind hbe_master hbe_monitor hbe_monitor_inst (.*);

// ==== hbe_periph.sv ====
// Purpose: Behavioural peripheral on the multiplexed bus.
// Assumes: No pull resistor on the shared bus.
// Notes: Ready held low for stall_i link edges per access.
module hbe_periph (
   // Clocks
   input wire logic clk_i,
   input wire logic lk_i,
   // From the master; stall_i from the bench
   input wire logic [7:0] ad_o_i,
   input wire logic ad_oe_i,
   input wire logic sel_n_i,
   input wire logic latch_i,
   input wire logic rd_n_i,
   input wire logic wr_n_i,
   input wire logic [3:0] stall_i,
   // Toward the master
   output logic [7:0] ad_o,
   output logic rdy_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [256];
   logic [7:0] lo, last;
   logic [3:0] cnt;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
      last = 8'h00;
      lo = 8'h00;
   end
   assign ad_o = ad_oe_i ? ad_o_i : (!sel_n_i && !rd_n_i) ? mem[lo] : ~last;
   assign rdy_o = !(!sel_n_i && cnt < stall_i);
   always @(posedge clk_i) begin
      last <= ad_o;
      if (latch_i) lo <= ad_o_i;
      if (!sel_n_i && !wr_n_i) mem[lo] <= ad_o_i;
   end
   always @(posedge lk_i or posedge sel_n_i) begin
      if (sel_n_i) cnt <= 4'h0;
      else if (cnt < 4'hF) cnt <= cnt + 4'h1;
   end
endmodule

// ==== tb.sv ====
// Purpose: Self-checking bench for the host bus emulation master.
// Assumes: Inputs change on the falling clock edge.
// Notes: Peripheral memory holds address xor 5A at start.
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb import hbe_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic CORE_CLK_I, SYS_RST_I, EMU_ENABLE_I, CMD_VALID_I;
   cmd_t CMD_I;
   logic [7:0] AD_I, AD_O, RESULT_O, ADDR_HIGH_O, res;
   logic ACCESS_READY_I, SPARE_ZERO_I, SPARE_WAIT_I, CMD_READY_O;
   logic RESULT_VALID_O, AD_OE_O, SEL_N_O, LATCH_O, RD_N_O, WR_N_O;
   logic INTERFACE_CLOCK_O, SPARE_ZERO_O, SPARE_ZERO_OE_O;
   logic SPARE_WAIT_O, SPARE_WAIT_OE_O, lk, irq, zext;
   logic [3:0] stall;
   int mismatches, samples_checked, rdlen;
   hbe_master hbe_master_inst (.*);
   hbe_periph hbe_periph_inst (.clk_i(CORE_CLK_I), .lk_i(lk),
      .ad_o_i(AD_O), .ad_oe_i(AD_OE_O), .sel_n_i(SEL_N_O),
      .latch_i(LATCH_O), .rd_n_i(RD_N_O), .wr_n_i(WR_N_O),
      .stall_i(stall), .ad_o(AD_I), .rdy_o(ACCESS_READY_I));
   assign SPARE_ZERO_I = SPARE_ZERO_OE_O ? SPARE_ZERO_O : zext;
   assign SPARE_WAIT_I = irq;
   initial begin
      CORE_CLK_I = 0;
      forever #5 CORE_CLK_I = ~CORE_CLK_I;
   end
   initial begin
      lk = 0;
      #3;
      forever #80 lk = ~lk;
   end
   always @(posedge CORE_CLK_I) begin
      if (RESULT_VALID_O === 1'b1) res <= RESULT_O;
      if (RD_N_O === 1'b0) rdlen <= rdlen + 1;
   end
   task idle;
      repeat (3000) if (CMD_READY_O !== 1'b1) @(negedge CORE_CLK_I);
      if (CMD_READY_O !== 1'b1) begin
         mismatches++;
         $display("unexpected cmd_ready exp 1 got %0b", CMD_READY_O);
         results;
      end
   endtask
   task cmd(input cmd_op_t op, input logic [15:0] a, input logic [7:0] d);
      idle;
      CMD_I = '{op, a, d};
      CMD_VALID_I = 1;
      @(negedge CORE_CLK_I);
      CMD_VALID_I = 0;
   endtask
   task t_wr;
      cmd(CMD_WRITE, 16'h12A5, 8'h3C);
      idle;
      `CHK("addr_high", 8'h12, ADDR_HIGH_O)
      `CHK("mem", 8'h3C, hbe_periph_inst.mem[8'hA5])
      cmd(CMD_READ, 16'h12A5, 8'h00);
      idle;
      `CHK("read", 8'h3C, res)
      `CHK("sel_idle", 1'b1, SEL_N_O)
      $display("test write_read done");
   endtask
   task t_stretch;
      int base;
      stall = 4'h3;
      base = rdlen;
      cmd(CMD_READ, 16'h0007, 8'h00);
      idle;
      stall = 4'h0;
      `CHK("read_slow", 8'h5D, res)
      `CHK("stretch", 1'b1, rdlen - base > 20)
      $display("test stretch done");
   endtask
   task t_spare;
      logic [7:0] d;
      int hi;
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 8'h03 : (i == 1) ? 8'h02 : 8'h00;
         cmd(CMD_SET_SPARE, 16'h0000, d);
         idle;
         `CHK("spare_oe", d[1], SPARE_ZERO_OE_O)
         cmd(CMD_READ_SPARE, 16'h0000, 8'h00);
         idle;
         `CHK("spare", {1'b0, d[1] ? d[0] : 1'b1}, res[1:0])
      end
      hi = 0;
      repeat (2 * IFCLK_HALF_CYCLES) begin
         @(negedge CORE_CLK_I);
         if (INTERFACE_CLOCK_O === 1'b1) hi++;
      end
      `CHK("ifclk_high", int'(IFCLK_HALF_CYCLES), hi)
      EMU_ENABLE_I = 0;
      repeat (3) @(negedge CORE_CLK_I);
      `CHK("ready_off", 1'b0, CMD_READY_O)
      EMU_ENABLE_I = 1;
      $display("test spare done");
   endtask
   task t_wait;
      for (int i = 0; i < 2; i++) begin
         irq = i[0];
         cmd(i ? CMD_WAIT_LOW : CMD_WAIT_HIGH, 16'h0000, 8'h00);
         repeat (20) @(negedge CORE_CLK_I);
         `CHK("stall", 1'b0, CMD_READY_O)
         irq = ~irq;
         idle;
         `CHK("resume", 1'b1, CMD_READY_O)
      end
      $display("test wait done");
   endtask
   task t_irq;
      int base;
      irq = 0;
      base = rdlen;
      cmd(CMD_IRQ_READ, 16'h0009, 8'h00);
      repeat (20) @(negedge CORE_CLK_I);
      `CHK("early_read", 0, rdlen - base)
      irq = 1;
      idle;
      `CHK("irq_read", 8'h53, res)
      `CHK("wait_oe", 1'b0, SPARE_WAIT_OE_O)
      $display("test irq done");
   endtask
   task results;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      SYS_RST_I = 1;
      EMU_ENABLE_I = 1;
      CMD_VALID_I = 0;
      CMD_I = '0;
      irq = 0;
      zext = 1;
      stall = 4'h0;
      repeat (10) @(negedge CORE_CLK_I);
      SYS_RST_I = 0;
      t_wr;
      t_stretch;
      t_spare;
      t_wait;
      t_irq;
      results;
   end
   initial begin
      #200000;
      mismatches++;
      results;
   end
endmodule
